// ===== can_ctrl_params.svh
// Constants of the CAN module control block: offsets, fields, reset values, timing
`ifndef CAN_CTRL_PARAMS_SVH
`define CAN_CTRL_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define MODCTRL_OFFSET      4'h0
`define ADDR_W              4

// ****************************************
// Field positions of module_control
// ****************************************
`define ABORT_BIT           27
`define REQ_MODE_HI         26
`define REQ_MODE_LO         24
`define CUR_MODE_HI         23
`define CUR_MODE_LO         21
`define CAP_EN_BIT          20
`define ON_BIT              15
`define STOP_IN_IDLE_BIT           13
`define BUSY_BIT            11
`define FILT_HI             4
`define FILT_LO             0
`define UNIMPL_MASK         32'hF00F_57E0

// ****************************************
// Reset values
// ****************************************
`define REQ_MODE_RST        3'h4
`define CUR_MODE_RST        3'h4

// ****************************************
// Timing
// ****************************************
`define MODE_SETTLE_NS      40
`define CLK_PERIOD_NS       10
`define MODE_SETTLE_CYC     ((`MODE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TS_W                16

`endif

// ===== can_ctrl_pkg.sv
// Types shared by the CAN module control block
package can_ctrl_pkg;

	// ****************************************
	// Operating modes
	// ****************************************
	typedef enum logic [2:0] {
		MODE_NORMAL   = 3'h0,
		MODE_DISABLE  = 3'h1,
		MODE_LOOPBACK = 3'h2,
		MODE_LISTEN   = 3'h3,
		MODE_CONFIG   = 3'h4,
		MODE_RSVD5    = 3'h5,
		MODE_RSVD6    = 3'h6,
		MODE_LISTALL  = 3'h7
	} op_mode_type;

	// Register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_type;

	// Received-message stamp record
	typedef struct packed {
		logic        valid;
		logic [15:0] stamp;
	} stamp_type;

endpackage

// ===== rx_timestamp_timer.sv
// Receive time-stamp timer, running only while capture is enabled, with capture on valid reception
`timescale 1ns/10ps
`default_nettype none
`include "can_ctrl_params.svh"
module rx_timestamp_timer
	import can_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic  sys_clk,
	input  wire logic  rst,
	// Control
	input  wire logic  captureEn,
	input  wire logic  rxValid,
	// Result
	output stamp_type  stampOut
);

	// ****************************************
	// Timer and capture
	// ****************************************
	logic [`TS_W-1:0] count_q;     // Running timer
	logic [`TS_W-1:0] count_d;
	stamp_type        stamp_q;     // Captured value
	stamp_type        stamp_d;

	// Timer halts while capture is off, which saves its toggling power [RULE_07]
	always_comb begin
		count_d = count_q;
		stamp_d = stamp_q;
		stamp_d.valid = 1'b0;
		if (captureEn) begin
			count_d = count_q + `TS_W'(1);
			if (rxValid) begin
				// Record the timer on each valid reception [RULE_06]
				stamp_d.valid = 1'b1;
				stamp_d.stamp = count_q;
			end
		end
	end

	// Registers only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			stamp_q <= '0;
		end else begin
			count_q <= count_d;
			stamp_q <= stamp_d;
		end
	end

	assign stampOut = stamp_q;

	chk_stamp_off: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_07]
		!captureEn |=> !stampOut.valid) else $error("stamp without capture");
	chk_stamp_take: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_06]
		captureEn && rxValid |=> stampOut.valid && stampOut.stamp == $past(count_q))
		else $error("stamp not captured");
	// A stopped timer must not creep, or stamps after a re-enable drift
	chk_timer_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_07]
		!captureEn |=> $stable(count_q)) else $error("timer ran while off");

endmodule
`default_nettype wire

// ===== can_module_control.sv
// Control register and mode sequencer of the CAN module
// Function
// [RULE_01] Abort request signals all transmit buffers
// [RULE_02] Abort clears itself when all aborted
// [RULE_03] Requested mode field selects operating mode
// [RULE_04] Software never writes reserved modes 101, 110
// [RULE_05] Current mode field shows actual mode
// [RULE_06] Capture enabled: stamp each valid reception (code stamps only while the module-on bit is also set)
// [RULE_07] Capture disabled: no stamps, timer stopped
// [RULE_08] Module-on bit enables or disables module
// [RULE_09] Disable waits for current bus transaction
// [RULE_10] Software polls active flag after disable
// [RULE_11] Unimplemented bits read as zero
// [RULE_12] Current mode changes only after transition
`timescale 1ns/10ps
`default_nettype none
`include "can_ctrl_params.svh"
module can_module_control
	import can_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	// Protocol engine side
	input  wire logic [7:0]  txPending,
	input  wire logic        busActive,
	input  wire logic        rxValid,
	output logic             abortAllTx,
	output logic             moduleEnable,
	output op_mode_type      opMode,
	output stamp_type        rxStamp,
	output logic             stopInIdle,
	output logic [4:0]       filterCount
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,   // Mode settled
		ST_WAIT   = 2'b01,   // Waiting for bus idle
		ST_SETTLE = 2'b11    // Switching mode
	} seq_type;

	reg_req_type req;                  // Bundled bus request
	seq_type     seq_q, seq_d;         // Mode sequencer
	op_mode_type reqMode_q, reqMode_d; // Requested mode
	op_mode_type curMode_q, curMode_d; // Mode in effect
	logic        abort_q, abort_d;     // Abort request
	logic        capEn_q, capEn_d;     // Capture enable
	logic        on_q, on_d;           // Module on
	logic        busy_q, busy_d;       // Module still active
	logic        stop_in_idle_q, stop_in_idle_d;     // Stop in idle (stored only)
	logic [4:0]  filt_q, filt_d;       // Filter count (stored only)
	logic [31:0] rdata_q, rdata_d;     // Read answer
	logic [2:0]  settle_q, settle_d;   // Settle counter
	logic        ctrlWrite;            // Write to control register

	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
	assign ctrlWrite = req.wr && (req.addr == `MODCTRL_OFFSET);

	// Read image of the control register; gaps stay zero [RULE_11]
	function automatic logic [31:0] ctrl_image(input logic ab, input op_mode_type rq,
			input op_mode_type cm, input logic ce, input logic on, input logic si,
			input logic bz, input logic [4:0] fc);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[`ABORT_BIT] = ab;
		v[`REQ_MODE_HI:`REQ_MODE_LO] = rq;
		v[`CUR_MODE_HI:`CUR_MODE_LO] = cm; // [RULE_05]
		v[`CAP_EN_BIT] = ce;
		v[`ON_BIT] = on;
		v[`STOP_IN_IDLE_BIT] = si;
		v[`BUSY_BIT] = bz;
		v[`FILT_HI:`FILT_LO] = fc;
		return v;
	endfunction

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		reqMode_d = reqMode_q;
		capEn_d   = capEn_q;
		on_d      = on_q;
		stop_in_idle_d   = stop_in_idle_q;
		filt_d    = filt_q;
		abort_d   = abort_q;
		curMode_d = curMode_q;
		seq_d     = seq_q;
		settle_d  = settle_q;
		rdata_d   = 32'h0000_0000;
		// Self-clear once no buffer still pends [RULE_02]
		if (abort_q && (txPending == 8'h00))
			abort_d = 1'b0;
		if (ctrlWrite) begin
			// Software may only set the abort; a set beats the clear [RULE_02]
			if (req.wdata[`ABORT_BIT])
				abort_d = 1'b1;
			// Reserved codes are left to software to avoid [RULE_04]
			reqMode_d = op_mode_type'(req.wdata[`REQ_MODE_HI:`REQ_MODE_LO]); // [RULE_03]
			capEn_d   = req.wdata[`CAP_EN_BIT];
			on_d      = req.wdata[`ON_BIT];
			stop_in_idle_d   = req.wdata[`STOP_IN_IDLE_BIT];
			filt_d    = req.wdata[`FILT_HI:`FILT_LO];
		end
		// Active until the bus transaction in flight is done [RULE_09]
		busy_d = on_q || busActive;
		unique case (seq_q)
			ST_IDLE: begin
				if (reqMode_q != curMode_q)
					seq_d = ST_WAIT;
			end
			ST_WAIT: begin
				// Settling only starts between bus transactions; bus activity during settle is not checked [RULE_09]
				if (!busActive) begin
					seq_d    = ST_SETTLE;
					settle_d = 3'(`MODE_SETTLE_CYC);
				end
			end
			ST_SETTLE: begin
				if (settle_q == 3'h1) begin
					curMode_d = reqMode_q; // Old mode visible till now [RULE_12]
					seq_d     = ST_IDLE;
				end else begin
					settle_d = settle_q - 3'h1;
				end
			end
			default: seq_d = ST_IDLE;
		endcase
		if (req.rd) begin
			if (req.addr == `MODCTRL_OFFSET)
				rdata_d = ctrl_image(abort_q, reqMode_q, curMode_q, capEn_q, on_q,
					stop_in_idle_q, busy_q, filt_q);
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seq_q     <= ST_IDLE;
			reqMode_q <= op_mode_type'(`REQ_MODE_RST);
			curMode_q <= op_mode_type'(`CUR_MODE_RST);
			abort_q   <= 1'b0;
			capEn_q   <= 1'b0;
			on_q      <= 1'b0;
			busy_q    <= 1'b0;
			stop_in_idle_q   <= 1'b0;
			filt_q    <= 5'h00;
			rdata_q   <= 32'h0000_0000;
			settle_q  <= 3'h0;
		end else begin
			seq_q     <= seq_d;
			reqMode_q <= reqMode_d;
			curMode_q <= curMode_d;
			abort_q   <= abort_d;
			capEn_q   <= capEn_d;
			on_q      <= on_d;
			busy_q    <= busy_d;
			stop_in_idle_q   <= stop_in_idle_d;
			filt_q    <= filt_d;
			rdata_q   <= rdata_d;
			settle_q  <= settle_d;
		end
	end

	// ****************************************
	// Time-stamp unit
	// ****************************************
	rx_timestamp_timer stampUnit (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.captureEn (capEn_q && on_q),
		.rxValid   (rxValid),
		.stampOut  (rxStamp)
	);

	// Outputs straight from flip-flops
	assign regRdata     = rdata_q;
	assign abortAllTx   = abort_q;   // [RULE_01]
	assign moduleEnable = on_q;      // [RULE_08]
	assign opMode       = curMode_q;
	assign stopInIdle   = stop_in_idle_q;
	assign filterCount  = filt_q;

	// ****************************************
	// Checks
	// ****************************************
	chk_abort_set: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_01]
		ctrlWrite && req.wdata[`ABORT_BIT] |=> abortAllTx) else $error("abort not raised");
	chk_abort_clear: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_02]
		abortAllTx && txPending == 8'h00 && !(ctrlWrite && req.wdata[`ABORT_BIT])
		|=> !abortAllTx) else $error("abort not cleared");
	// Software cannot withdraw an abort while buffers still pend
	chk_abort_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_02]
		abortAllTx && txPending != 8'h00 |=> abortAllTx) else $error("abort dropped early");
	chk_mode_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_12]
		seq_q != ST_SETTLE |=> $stable(curMode_q)) else $error("mode changed early");
	chk_mode_bus: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_09]
		seq_q == ST_WAIT && busActive |=> seq_q == ST_WAIT) else $error("mode left mid-frame");
	// Busy must cover a transaction in flight even after the module is off
	chk_busy_bus: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_09]
		busActive |=> busy_q) else $error("busy flag missed transaction");
	chk_mode_reach: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
		seq_q == ST_SETTLE && settle_q == 3'h1 |=> curMode_q == $past(reqMode_q))
		else $error("mode not reached");
	chk_read_zero: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_11]
		req.rd |=> (regRdata & `UNIMPL_MASK) == 32'h0000_0000) else $error("gap bit set");
	chk_read_mode: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_05]
		req.rd && req.addr == `MODCTRL_OFFSET |=> regRdata[23:21] == $past(curMode_q))
		else $error("mode readback wrong");
	chk_on_follow: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
		ctrlWrite |=> moduleEnable == $past(req.wdata[`ON_BIT])) else $error("on bit lost");

	cov_abort: cover property (@(posedge sys_clk) abortAllTx ##1 !abortAllTx);
	cov_mode: cover property (@(posedge sys_clk) seq_q == ST_SETTLE ##1 seq_q == ST_IDLE);
	cov_stamp: cover property (@(posedge sys_clk) rxStamp.valid);
	cov_bus_wait: cover property (@(posedge sys_clk) seq_q == ST_WAIT && busActive);

endmodule
`default_nettype wire

// ===== can_engine_model.sv
// Stand-in for the protocol engine beside the module control block
`timescale 1ns/10ps
`default_nettype none
module can_engine_model (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Bench commands
	input  wire logic [7:0] loadPend,
	input  wire logic       busReq,
	input  wire logic       rxReq,
	// Block side
	input  wire logic       abortAllTx,
	output logic      [7:0] txPending,
	output logic            busActive,
	output logic            rxValid
);
	// Buffers give up one per cycle, lowest first, so an abort spans several cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txPending <= 8'h00;
		end else if (loadPend != 8'h00) begin
			txPending <= txPending | loadPend;
		end else if (abortAllTx) begin
			txPending <= txPending & (txPending - 8'h01);
		end
	end
	// Bus activity and reception pulses follow the bench
	assign busActive = busReq;
	assign rxValid   = rxReq;
endmodule
`default_nettype wire

// ===== can_module_control_tb.sv
// Self-checking bench of the CAN module control block
`timescale 1ns/10ps
`default_nettype none
module can_module_control_tb;
	import can_ctrl_pkg::*;
	// ****
	// Signals
	// ****
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWdata = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] regRdata;
	logic [7:0]  txPending;
	logic [7:0]  loadPend = 8'h00;
	logic        busActive;
	logic        rxValid;
	logic        busReq = 1'b0;
	logic        rxReq = 1'b0;
	logic        abortAllTx;
	logic        moduleEnable;
	logic        stopInIdle;
	logic [4:0]  filterCount;
	op_mode_type opMode;
	stamp_type   rxStamp;
	logic [31:0] rd;
	logic [15:0] t0;
	logic [15:0] t1;
	int          n;
	int          error_cnt = 0;
	int          num_checks = 0;
	// Mode rows: requested code beside its image; no reserved code
	typedef struct {op_mode_type mode; logic [31:0] image;} row_type;
	row_type rows [6] = '{'{MODE_NORMAL, 32'h00000000}, '{MODE_DISABLE, 32'h01200000},
		'{MODE_LOOPBACK, 32'h02400000}, '{MODE_LISTEN, 32'h03600000},
		'{MODE_LISTALL, 32'h07E00000}, '{MODE_CONFIG, 32'h04800000}};
	op_mode_type prev = MODE_CONFIG;

	always #5 sys_clk = ~sys_clk;

	can_module_control i_can_module_control (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.txPending(txPending), .busActive(busActive), .rxValid(rxValid),
		.abortAllTx(abortAllTx), .moduleEnable(moduleEnable), .opMode(opMode),
		.rxStamp(rxStamp), .stopInIdle(stopInIdle), .filterCount(filterCount));
	can_engine_model i_can_engine_model (.sys_clk(sys_clk), .rst(rst), .loadPend(loadPend),
		.busReq(busReq), .rxReq(rxReq), .abortAllTx(abortAllTx), .txPending(txPending),
		.busActive(busActive), .rxValid(rxValid));

	// ****
	// Tasks
	// ****
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// A wait that ran out of cycles ends the run
	task automatic guard(input int cnt);
		if (cnt >= 40) begin
			check(32'h0, 32'h1);
			complete_run();
		end
	endtask
	task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic regRead(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic pulseRx(input logic expV, output logic [15:0] s);
		@(posedge sys_clk);
		rxReq <= 1'b1;
		@(posedge sys_clk);
		rxReq <= 1'b0;
		#1 s = rxStamp.stamp;
		check({31'h0, rxStamp.valid}, {31'h0, expV});
	endtask

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge sys_clk);
		check(32'h0, 32'h1);
		complete_run();
	end

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		regRead(4'h0, rd);
		check(rd, 32'h04800000);
		for (int i = 0; i < 6; i++) begin
			regWrite(4'h0, {5'h0, rows[i].mode, 24'h0});
			#1 check({29'h0, opMode}, {29'h0, prev});
			for (n = 0; n < 40 && opMode !== rows[i].mode; n++) @(posedge sys_clk);
			guard(n);
			regRead(4'h0, rd);
			check(rd, rows[i].image);
			prev = rows[i].mode;
		end
		// Abort: holds against a written zero, clears itself once all pending are gone
		@(posedge sys_clk);
		loadPend <= 8'hFF;
		@(posedge sys_clk);
		loadPend <= 8'h00;
		regWrite(4'h0, 32'h0C000000);
		#1 check({31'h0, abortAllTx}, 32'h1);
		regWrite(4'h0, 32'h04000000);
		#1 check({31'h0, abortAllTx}, 32'h1);
		for (n = 0; n < 40 && abortAllTx === 1'b1; n++) @(posedge sys_clk);
		guard(n);
		check({24'h0, txPending}, 32'h0);
		// Unmapped place, then every writable bit but the abort set
		regWrite(4'h4, 32'hFFFFFFFF);
		regRead(4'h4, rd);
		check(rd, 32'h0);
		regRead(4'h0, rd);
		check(rd, 32'h04800000);
		regWrite(4'h0, 32'hF7FFFFFF);
		regRead(4'h0, rd);
		check(rd & 32'hF00F57E0, 32'h0);
		check(rd, 32'h0790A81F);
		check({31'h0, moduleEnable}, 32'h1);
		check({31'h0, stopInIdle}, 32'h1);
		check({27'h0, filterCount}, 32'h1F);
		// Stamps six cycles apart differ by six
		pulseRx(1'b1, t0);
		repeat (4) @(posedge sys_clk);
		pulseRx(1'b1, t1);
		check({16'h0, t1 - t0}, 32'h6);
		regWrite(4'h0, 32'h07008000);
		pulseRx(1'b0, t1);
		// Switch off and ask for config while a bus transaction runs
		@(posedge sys_clk);
		busReq <= 1'b1;
		regWrite(4'h0, 32'h04000000);
		repeat (10) @(posedge sys_clk);
		check({29'h0, opMode}, {29'h0, MODE_LISTALL});
		regRead(4'h0, rd);
		check({31'h0, rd[11]}, 32'h1);
		busReq <= 1'b0;
		for (n = 0; n < 40 && rd[11] !== 1'b0; n++) regRead(4'h0, rd);
		guard(n);
		check({31'h0, moduleEnable}, 32'h0);
		for (n = 0; n < 40 && opMode !== MODE_CONFIG; n++) @(posedge sys_clk);
		guard(n);
		check({29'h0, opMode}, {29'h0, MODE_CONFIG});
		// Reset in mid-run with the module on and capturing
		regWrite(4'h0, 32'h07108000);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1 check({31'h0, moduleEnable}, 32'h0);
		check({29'h0, opMode}, {29'h0, MODE_CONFIG});
		check({15'h0, rxStamp}, 32'h0);
		regRead(4'h0, rd);
		check(rd, 32'h04800000);
		complete_run();
	end
endmodule
`default_nettype wire
